// File: verilog/backlight_control_timer_regs.sv
// Purpose: Backlight mode, interrupt enable, control and timer registers
// Assumes: Serial interface already decoded into a byte register port
// Notes: Reads return data one cycle after reg_rd
//
// Overview of operation
// - Dummy load on when enabled and code below 8 linear or 32 square.
// - Comparator interrupt enable gates comparator status onto the interrupt line.
// - Overvoltage interrupt enable gates overvoltage status onto the interrupt line.
// - Level field bits 7-6: 00 daylight, 01 office, 10 dark.
// - Law field bits 5-4: linear, square, cubic one, cubic two.
// - Auto adjust clear: comparators ignored, software level used.
// - Auto adjust set: comparators drive the level field, not software.
// - Control bit 2 enables soft overvoltage protection.
// - Control bit 1 enables fade override.
// - Off timer code 0 disables; else 10-40 s by 5, 50-120 s by 10.
// - Dim timer uses the off timer encoding.
// - Fade-out code 0 disables; 0.3-3.0 s by 0.3, 3.5-5.5 s by 0.5.
// - Fade-in timer uses the fade-out encoding.
// - Backlight enable bit turns the driver on and off.
// - Dim timer sets dim bit itself and clears it on expiry.
// - Interrupt status bits are sticky and cleared by writing one.
`timescale 1ns/1ps
module backlight_control_timer_regs #(
  parameter int TICK_CYCLES = backlight_regs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Analog side status
  input wire logic ovp_detect,
  input wire logic comparator_trip,
  input wire logic level2_out,
  input wire logic level3_out,
  input wire logic [6:0] backlight_code,
  // Interrupt line
  output logic irq,
  // Control outputs
  output logic standby_n,
  output logic backlight_enable,
  output logic dim_mode,
  output logic dummy_load_on,
  output logic [1:0] brightness_level,
  output logic [1:0] fade_law,
  output logic soft_overvoltage_enable,
  output logic fade_override,
  output logic [5:0] fade_in_ticks,
  output logic [5:0] fade_out_ticks
);
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] ien_r;
  logic [7:0] ien_nxt;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic [7:0] time_r;
  logic [7:0] time_nxt;
  logic [7:0] fade_r;
  logic [7:0] fade_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [5:0] fin_r;
  logic [5:0] fin_nxt;
  logic [5:0] fout_r;
  logic [5:0] fout_nxt;
  logic load_r;
  logic load_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [31:0] presc_r;
  logic [31:0] presc_nxt;
  logic tick_r;
  logic tick_nxt;
  logic auto_dim_r;
  logic auto_dim_nxt;
  logic light_en_d_r;
  logic bl_start;
  logic bl_stop;
  logic off_expired;
  logic dim_expired;
  logic [1:0] auto_level;

  function automatic logic hit(input logic [7:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction : hit

  // Write-one-to-clear; a zero written leaves the status bit alone
  function automatic logic w1c(input logic old, input logic wbit);
    return old && !wbit;
  endfunction : w1c

  // Dummy load window per fade law; cubic laws never ask for it
  function automatic logic load_window(input logic [1:0] law, input logic [6:0] code);
    logic want;
    want = 1'b0;
    if (law == backlight_regs_pkg::LAW_LINEAR) begin
      want = (code < backlight_regs_pkg::LOAD_LIMIT_LINEAR);
    end else if (law == backlight_regs_pkg::LAW_SQUARE) begin
      want = (code < backlight_regs_pkg::LOAD_LIMIT_SQUARE);
    end
    return want;
  endfunction : load_window

  // Read decode; unmapped offsets read zero
  function automatic logic [7:0] read_value(input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    if (ofs == backlight_regs_pkg::OFS_MODE) begin
      v = mode_r;
    end else if (ofs == backlight_regs_pkg::OFS_IRQ_LOAD_EN) begin
      v = ien_r;
    end else if (ofs == backlight_regs_pkg::OFS_LIGHT_CONTROL) begin
      v = ctl_r;
    end else if (ofs == backlight_regs_pkg::OFS_BL_TIMERS) begin
      v = time_r;
    end else if (ofs == backlight_regs_pkg::OFS_BL_FADE) begin
      v = fade_r;
    end
    return v;
  endfunction : read_value

  // Shared 0.1 s time base for both interval timers
  always_comb begin
    tick_nxt = 1'b0;
    presc_nxt = presc_r + 32'h1;
    if (presc_r >= 32'(TICK_CYCLES - 1)) begin
      presc_nxt = 32'h0;
      tick_nxt = 1'b1;
    end
  end

  // Only the enable edge starts a countdown, so a held bit never restarts it
  assign bl_start = mode_r[backlight_regs_pkg::MODE_LIGHT_EN_BIT] && !light_en_d_r;
  assign bl_stop = !mode_r[backlight_regs_pkg::MODE_LIGHT_EN_BIT];

  // Cancel wins over start, so clearing the enable stops both at once
  interval_timer u_off_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .tick(tick_r),
    .start(bl_start),
    .cancel(bl_stop),
    .code(time_r[backlight_regs_pkg::HI_MSB:backlight_regs_pkg::HI_LSB]),
    .running(),
    .expired(off_expired)
  );

  interval_timer u_dim_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .tick(tick_r),
    .start(bl_start),
    .cancel(bl_stop),
    .code(time_r[backlight_regs_pkg::LO_MSB:backlight_regs_pkg::LO_LSB]),
    .running(),
    .expired(dim_expired)
  );

  // Comparator outputs mapped to an operating level, dark taking priority
  always_comb begin
    if (level3_out) begin
      auto_level = backlight_regs_pkg::LEVEL_DARK;
    end else if (level2_out) begin
      auto_level = backlight_regs_pkg::LEVEL_OFFICE;
    end else begin
      auto_level = backlight_regs_pkg::LEVEL_DAYLIGHT;
    end
  end

  // Register writes and hardware updates
  always_comb begin
    mode_nxt = mode_r;
    ien_nxt = ien_r;
    ctl_nxt = ctl_r;
    time_nxt = time_r;
    fade_nxt = fade_r;
    auto_dim_nxt = auto_dim_r;
    if (hit(backlight_regs_pkg::OFS_MODE)) begin
      mode_nxt[7:5] = reg_wdata[7:5];
      mode_nxt[backlight_regs_pkg::MODE_OVP_ST_BIT] = w1c(
        mode_r[backlight_regs_pkg::MODE_OVP_ST_BIT],
        reg_wdata[backlight_regs_pkg::MODE_OVP_ST_BIT]);
      mode_nxt[backlight_regs_pkg::MODE_CMP_ST_BIT] = w1c(
        mode_r[backlight_regs_pkg::MODE_CMP_ST_BIT],
        reg_wdata[backlight_regs_pkg::MODE_CMP_ST_BIT]);
      // A hand write to the dim bit takes it away from the timer
      auto_dim_nxt = 1'b0;
    end
    if (hit(backlight_regs_pkg::OFS_IRQ_LOAD_EN)) begin
      ien_nxt = reg_wdata & backlight_regs_pkg::MASK_IRQ_LOAD_EN;
    end
    if (hit(backlight_regs_pkg::OFS_LIGHT_CONTROL)) begin
      ctl_nxt = reg_wdata & backlight_regs_pkg::MASK_LIGHT_CONTROL;
      if (ctl_r[backlight_regs_pkg::AUTO_ADJ_BIT]) begin
        ctl_nxt[backlight_regs_pkg::LEVEL_MSB:backlight_regs_pkg::LEVEL_LSB] =
          ctl_r[backlight_regs_pkg::LEVEL_MSB:backlight_regs_pkg::LEVEL_LSB];
      end
    end
    if (hit(backlight_regs_pkg::OFS_BL_TIMERS)) begin
      time_nxt = reg_wdata;
    end
    if (hit(backlight_regs_pkg::OFS_BL_FADE)) begin
      fade_nxt = reg_wdata;
    end
    // Level follows comparators only while auto adjust is on
    if (ctl_nxt[backlight_regs_pkg::AUTO_ADJ_BIT]) begin
      ctl_nxt[backlight_regs_pkg::LEVEL_MSB:backlight_regs_pkg::LEVEL_LSB] = auto_level;
    end
    // Timer driven dim: set on enable, cleared on expiry
    if (bl_start && (time_r[backlight_regs_pkg::LO_MSB:backlight_regs_pkg::LO_LSB] != 4'h0)) begin
      mode_nxt[backlight_regs_pkg::MODE_DIM_BIT] = 1'b1;
      auto_dim_nxt = 1'b1;
    end else if (dim_expired && auto_dim_r) begin
      mode_nxt[backlight_regs_pkg::MODE_DIM_BIT] = 1'b0;
      auto_dim_nxt = 1'b0;
    end
    if (off_expired) begin
      mode_nxt[backlight_regs_pkg::MODE_LIGHT_EN_BIT] = 1'b0;
    end
    // Events set after the clear so a same-cycle event is kept
    if (ovp_detect) begin
      mode_nxt[backlight_regs_pkg::MODE_OVP_ST_BIT] = 1'b1;
    end
    if (comparator_trip) begin
      mode_nxt[backlight_regs_pkg::MODE_CMP_ST_BIT] = 1'b1;
    end
    mode_nxt = mode_nxt & backlight_regs_pkg::MASK_MODE;
  end

  // Derived outputs and read data
  always_comb begin
    // Irq is a registered level one cycle behind status, not a pulse
    irq_nxt = (mode_r[backlight_regs_pkg::MODE_CMP_ST_BIT] &&
               ien_r[backlight_regs_pkg::CMP_IEN_BIT]) ||
              (mode_r[backlight_regs_pkg::MODE_OVP_ST_BIT] &&
               ien_r[backlight_regs_pkg::OVP_IRQ_EN_BIT]);
    load_nxt = 1'b0;
    if (ien_r[backlight_regs_pkg::DUMMY_LOAD_EN_BIT]) begin
      load_nxt = load_window(fade_law, backlight_code);
    end
    fout_nxt = backlight_regs_pkg::fade_ticks(
      fade_r[backlight_regs_pkg::HI_MSB:backlight_regs_pkg::HI_LSB]);
    fin_nxt = backlight_regs_pkg::fade_ticks(
      fade_r[backlight_regs_pkg::LO_MSB:backlight_regs_pkg::LO_LSB]);
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = read_value(reg_addr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_r <= backlight_regs_pkg::RESET_VALUE;
      ien_r <= backlight_regs_pkg::RESET_VALUE;
      ctl_r <= backlight_regs_pkg::RESET_VALUE;
      time_r <= backlight_regs_pkg::RESET_VALUE;
      fade_r <= backlight_regs_pkg::RESET_VALUE;
      rdata_r <= 8'h00;
      fin_r <= 6'h00;
      fout_r <= 6'h00;
      load_r <= 1'b0;
      irq_r <= 1'b0;
      presc_r <= 32'h0;
      tick_r <= 1'b0;
      auto_dim_r <= 1'b0;
      light_en_d_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      ien_r <= ien_nxt;
      ctl_r <= ctl_nxt;
      time_r <= time_nxt;
      fade_r <= fade_nxt;
      rdata_r <= rdata_nxt;
      fin_r <= fin_nxt;
      fout_r <= fout_nxt;
      load_r <= load_nxt;
      irq_r <= irq_nxt;
      presc_r <= presc_nxt;
      tick_r <= tick_nxt;
      auto_dim_r <= auto_dim_nxt;
      light_en_d_r <= mode_r[backlight_regs_pkg::MODE_LIGHT_EN_BIT];
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign dummy_load_on = load_r;
  assign standby_n = mode_r[backlight_regs_pkg::MODE_STANDBY_BIT];
  assign backlight_enable = mode_r[backlight_regs_pkg::MODE_LIGHT_EN_BIT];
  assign dim_mode = mode_r[backlight_regs_pkg::MODE_DIM_BIT];
  assign brightness_level =
    ctl_r[backlight_regs_pkg::LEVEL_MSB:backlight_regs_pkg::LEVEL_LSB];
  assign fade_law = ctl_r[backlight_regs_pkg::LAW_MSB:backlight_regs_pkg::LAW_LSB];
  assign soft_overvoltage_enable = ctl_r[backlight_regs_pkg::SOFT_OVP_BIT];
  assign fade_override = ctl_r[backlight_regs_pkg::FADE_OVR_BIT];
  assign fade_in_ticks = fin_r;
  assign fade_out_ticks = fout_r;
endmodule : backlight_control_timer_regs

// File: include/backlight_regs_pkg.sv
// Purpose: Shared constants for the backlight configuration and timer block
// Assumes: 125 MHz ref_clk, timers counted in 0.1 s ticks
// Notes: Timer decode functions are shared by the top and the timer module
package backlight_regs_pkg;
  // Register offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_IRQ_LOAD_EN = 8'h01;
  localparam logic [7:0] OFS_LIGHT_CONTROL = 8'h02;
  localparam logic [7:0] OFS_BL_TIMERS = 8'h03;
  localparam logic [7:0] OFS_BL_FADE = 8'h04;

  // Mode register fields
  localparam int MODE_STANDBY_BIT = 7;
  localparam int MODE_LIGHT_EN_BIT = 6;
  localparam int MODE_DIM_BIT = 5;
  localparam int MODE_OVP_ST_BIT = 4;
  localparam int MODE_CMP_ST_BIT = 3;

  // Interrupt and load enable fields
  localparam int DUMMY_LOAD_EN_BIT = 4;
  localparam int CMP_IEN_BIT = 3;
  localparam int OVP_IRQ_EN_BIT = 2;

  // Backlight control fields
  localparam int LEVEL_MSB = 7;
  localparam int LEVEL_LSB = 6;
  localparam int LAW_MSB = 5;
  localparam int LAW_LSB = 4;
  localparam int AUTO_ADJ_BIT = 3;
  localparam int SOFT_OVP_BIT = 2;
  localparam int FADE_OVR_BIT = 1;

  // Timer fields (same nibble split in both timer registers)
  localparam int HI_MSB = 7;
  localparam int HI_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;

  // Writable bit masks; other positions ignore writes and read zero
  localparam logic [7:0] MASK_MODE = 8'hF8;
  localparam logic [7:0] MASK_IRQ_LOAD_EN = 8'h1C;
  localparam logic [7:0] MASK_LIGHT_CONTROL = 8'hFE;
  localparam logic [7:0] MASK_TIMERS = 8'hFF;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Brightness levels
  localparam logic [1:0] LEVEL_DAYLIGHT = 2'h0;
  localparam logic [1:0] LEVEL_OFFICE = 2'h1;
  localparam logic [1:0] LEVEL_DARK = 2'h2;

  // Fade laws
  localparam logic [1:0] LAW_LINEAR = 2'h0;
  localparam logic [1:0] LAW_SQUARE = 2'h1;
  localparam logic [1:0] LAW_CUBIC1 = 2'h2;
  localparam logic [1:0] LAW_CUBIC2 = 2'h3;

  // Dummy load thresholds on the backlight code
  localparam logic [6:0] LOAD_LIMIT_LINEAR = 7'h08;
  localparam logic [6:0] LOAD_LIMIT_SQUARE = 7'h20;

  // Time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

  // Timer encodings, in ticks of TICK_MS
  localparam int LONG_FIRST_TICKS = 100;
  localparam int LONG_STEP1_TICKS = 50;
  localparam int LONG_KNEE_CODE = 8;
  localparam int LONG_KNEE_TICKS = 500;
  localparam int LONG_STEP2_TICKS = 100;
  localparam int FADE_STEP1_TICKS = 3;
  localparam int FADE_KNEE_CODE = 11;
  localparam int FADE_KNEE_TICKS = 35;
  localparam int FADE_STEP2_TICKS = 5;
  localparam int TIMER_W = 11;
  localparam int FADE_W = 6;

  // Off and dim timers: 10..40 s by 5 s, then 50..120 s by 10 s
  function automatic logic [10:0] long_ticks(input logic [3:0] code);
    int t;
    t = 0;
    if (code == 4'h0) begin
      t = 0;
    end else if (int'(code) < LONG_KNEE_CODE) begin
      t = LONG_FIRST_TICKS + LONG_STEP1_TICKS * (int'(code) - 1);
    end else begin
      t = LONG_KNEE_TICKS + LONG_STEP2_TICKS * (int'(code) - LONG_KNEE_CODE);
    end
    return t[10:0];
  endfunction : long_ticks

  // Fade timers: 0.3..3.0 s by 0.3 s, then 3.5..5.5 s by 0.5 s
  function automatic logic [5:0] fade_ticks(input logic [3:0] code);
    int t;
    t = 0;
    if (int'(code) < FADE_KNEE_CODE) begin
      t = FADE_STEP1_TICKS * int'(code);
    end else begin
      t = FADE_KNEE_TICKS + FADE_STEP2_TICKS * (int'(code) - FADE_KNEE_CODE);
    end
    return t[5:0];
  endfunction : fade_ticks
endpackage : backlight_regs_pkg

// File: verilog/interval_timer.sv
// Purpose: Countdown of an off or dim interval in 0.1 s ticks
// Assumes: tick is a one-cycle pulse from the shared prescaler
// Notes: Code 0 never starts; cancel wins over start
`timescale 1ns/1ps
module interval_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic cancel,
  input wire logic [3:0] code,
  // Status
  output logic running,
  output logic expired
);
  logic [10:0] count_r;
  logic [10:0] count_nxt;
  logic run_r;
  logic run_nxt;
  logic exp_r;
  logic exp_nxt;

  always_comb begin
    count_nxt = count_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (cancel) begin
      run_nxt = 1'b0;
    end else if (start) begin
      count_nxt = backlight_regs_pkg::long_ticks(code);
      run_nxt = (code != 4'h0);
    end else if (run_r && tick) begin
      if (count_r <= 11'h001) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
        count_nxt = 11'h000;
      end else begin
        count_nxt = count_r - 11'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_r <= 11'h000;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign running = run_r;
  assign expired = exp_r;
endmodule : interval_timer

// File: dv/backlight_regs_properties.sv
// Purpose: Port-level properties of the backlight register block
// Assumes: One clock, synchronous active-high reset
// Notes: Enables and auto bit are shadowed from the write stream
`timescale 1ns/1ps
module backlight_regs_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Analog side
  input wire logic ovp_detect,
  input wire logic comparator_trip,
  input wire logic level2_out,
  input wire logic level3_out,
  input wire logic [6:0] backlight_code,
  // Outputs
  input wire logic irq,
  input wire logic backlight_enable,
  input wire logic dummy_load_on,
  input wire logic [1:0] brightness_level,
  input wire logic [1:0] fade_law,
  input wire logic soft_overvoltage_enable,
  input wire logic fade_override,
  input wire logic [5:0] fade_out_ticks
);
  logic [2:0] en_r, en_nxt;
  logic auto_r, auto_nxt, load_exp;
  logic [1:0] lvl_exp;

  function automatic logic [5:0] fade_len(input logic [7:0] c);
    return (c[7:4] < 4'hB) ? 6'(3 * c[7:4]) : 6'(35 + 5 * (c[7:4] - 4'hB));
  endfunction : fade_len

  always_comb begin
    en_nxt = en_r;
    auto_nxt = auto_r;
    if (reg_wr && reg_addr == 8'h01) en_nxt = reg_wdata[4:2];
    if (reg_wr && reg_addr == 8'h02) auto_nxt = reg_wdata[3];
    load_exp = en_r[2] && ((fade_law == 2'h0 && backlight_code < 7'h08) ||
      (fade_law == 2'h1 && backlight_code < 7'h20));
    lvl_exp = level3_out ? 2'h2 : (level2_out ? 2'h1 : 2'h0);
  end

  always_ff @(posedge ref_clk) begin
    en_r <= reset ? 3'h0 : en_nxt;
    auto_r <= reset ? 1'b0 : auto_nxt;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence wr_to(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  ovp_irq_raise_a: assert property (ovp_detect && en_r[0] |-> ##2 irq)
    else $error("overvoltage event did not raise irq");
  cmp_irq_raise_a: assert property (comparator_trip && en_r[1] |-> ##2 irq)
    else $error("comparator event did not raise irq");
  irq_masked_a: assert property (wr_to(8'h01) ##0 reg_wdata[3:2] == 2'h0 |-> ##2 !irq)
    else $error("irq high with both sources masked");
  dummy_load_a: assert property (1'b1 |=> dummy_load_on == $past(load_exp))
    else $error("dummy load request wrong");
  auto_level_a: assert property (auto_r && !(reg_wr && reg_addr == 8'h02)
    |=> brightness_level == $past(lvl_exp)) else $error("auto level not from comparators");
  manual_level_a: assert property (!auto_r && !(reg_wr && reg_addr == 8'h02)
    |=> $stable(brightness_level)) else $error("level moved without a write");
  ctl_write_a: assert property (wr_to(8'h02) ##0 !auto_r
    |=> {brightness_level, fade_law, 1'b0, soft_overvoltage_enable, fade_override, 1'b0}
    == ({($past(reg_wdata[3]) ? $past(lvl_exp) : $past(reg_wdata[7:6])), $past(reg_wdata[5:0])}
    & 8'hF6)) else $error("control fields differ from write");
  fade_decode_a: assert property (wr_to(8'h04)
    |-> ##2 fade_out_ticks == fade_len($past(reg_wdata, 2))) else $error("fade-out decode");
  unmapped_read_a: assert property (reg_rd && reg_addr > 8'h04 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  enable_write_a: assert property (wr_to(8'h00) |=> backlight_enable == $past(reg_wdata[6]))
    else $error("backlight enable differs from write");
endmodule : backlight_regs_properties

bind backlight_control_timer_regs backlight_regs_properties backlight_regs_properties_inst (
  .ref_clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .ovp_detect,
  .comparator_trip, .level2_out, .level3_out, .backlight_code, .irq, .backlight_enable,
  .dummy_load_on, .brightness_level, .fade_law, .soft_overvoltage_enable, .fade_override,
  .fade_out_ticks);

// File: dv/host_model.sv
// Purpose: Host side of the byte register port
// Assumes: Strobes launched 1 ns after the rising edge
// Notes: Idle address and data show inverted values, never the last ones
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd

  // Timers first, so the countdown started by the enable uses them
  task automatic start_light(input logic [7:0] t, input logic [7:0] f);
    wr(8'h03, t);
    wr(8'h04, f);
    wr(8'h00, 8'hC0);
  endtask : start_light
endmodule : host_model

// File: dv/testbench.sv
// Purpose: Self-checking bench for the backlight register block
// Assumes: Tick shortened to four clocks
// Notes: Register traffic goes through the host model tasks
`timescale 1ns/1ps
module testbench;
  localparam int TICKS = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, ovp_detect, comparator_trip, level2_out, level3_out, irq, e;
  logic standby_n, backlight_enable, dim_mode, dummy_load_on;
  logic soft_overvoltage_enable, fade_override;
  logic [1:0] brightness_level, fade_law;
  logic [5:0] fade_in_ticks, fade_out_ticks;
  logic [6:0] backlight_code;
  logic [6:0] codes [4] = '{7'h07, 7'h08, 7'h1F, 7'h20};
  int fail_count = 0;
  int check_count = 0;
  int n;

  always #4 ref_clk = ~ref_clk;

  backlight_control_timer_regs #(.TICK_CYCLES(TICKS)) backlight_control_timer_regs_inst (
    .ref_clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .ovp_detect,
    .comparator_trip, .level2_out, .level3_out, .backlight_code, .irq, .standby_n,
    .backlight_enable, .dim_mode, .dummy_load_on, .brightness_level, .fade_law,
    .soft_overvoltage_enable, .fade_override, .fade_in_ticks, .fade_out_ticks);

  host_model host_model_inst (.ref_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.rd(a, rv);
    chk("readback", exp, rv);
  endtask : rd_chk

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Bounded wait while a flag stays high; n counts the cycles
  task automatic hold_time(input logic dim);
    n = 0;
    while ((dim ? dim_mode : backlight_enable) === 1'b1 && n < 200 * TICKS) begin
      cyc(1);
      n++;
    end
    e = n >= 99 * TICKS && n <= 102 * TICKS;
    chk("interval", 8'h01, {7'h00, e});
    if (n >= 200 * TICKS) complete_run();
  endtask : hold_time

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    {ovp_detect, comparator_trip, level2_out, level3_out} = 4'h0;
    backlight_code = 7'h00;
    repeat (12) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    for (int a = 0; a < 6; a++) rd_chk(8'(a), 8'h00);
    rd_chk(8'hFF, 8'h00);
    host_model_inst.wr(8'h01, 8'hFF);
    rd_chk(8'h01, 8'h1C);
    host_model_inst.wr(8'h02, 8'h77);
    rd_chk(8'h02, 8'h76);
    chk("controls", 8'h7C, {brightness_level, fade_law, soft_overvoltage_enable,
      fade_override, 2'h0});
    host_model_inst.wr(8'h03, 8'hA5);
    rd_chk(8'h03, 8'hA5);
    level3_out = 1'b1;
    host_model_inst.wr(8'h02, 8'h08);
    cyc(2);
    chk("auto dark", 8'h02, {6'h00, brightness_level});
    {level3_out, level2_out} = 2'h1;
    cyc(2);
    rd_chk(8'h02, 8'h48);
    host_model_inst.wr(8'h02, 8'h00);
    host_model_inst.wr(8'h02, 8'h80);
    cyc(2);
    rd_chk(8'h02, 8'h80);
    host_model_inst.wr(8'h01, 8'h10);
    for (int l = 0; l < 4; l++) begin
      host_model_inst.wr(8'h02, 8'(l * 16));
      chk("law", 8'(l), {6'h00, fade_law});
      foreach (codes[j]) begin
        backlight_code = codes[j];
        cyc(2);
        e = (l == 0 && codes[j] < 7'h08) || (l == 1 && codes[j] < 7'h20);
        chk("dummy load", {7'h00, e}, {7'h00, dummy_load_on});
      end
    end
    host_model_inst.wr(8'h01, 8'h00);
    cyc(2);
    chk("load off", 8'h00, {7'h00, dummy_load_on});
    for (int i = 0; i < 16; i++) begin
      host_model_inst.wr(8'h04, 8'(i * 17));
      cyc(1);
      n = (i < 11) ? 3 * i : 35 + 5 * (i - 11);
      chk("fade out", 8'(n), {2'h0, fade_out_ticks});
      chk("fade in", 8'(n), {2'h0, fade_in_ticks});
    end
    host_model_inst.wr(8'h01, 8'h04);
    ovp_detect = 1'b1;
    cyc(1);
    {ovp_detect, comparator_trip} = 2'h1;
    cyc(1);
    comparator_trip = 1'b0;
    cyc(2);
    chk("irq", 8'h01, {7'h00, irq});
    rd_chk(8'h00, 8'h18);
    host_model_inst.wr(8'h00, 8'h10);
    cyc(2);
    chk("irq", 8'h00, {7'h00, irq});
    rd_chk(8'h00, 8'h08);
    host_model_inst.wr(8'h01, 8'h08);
    cyc(2);
    chk("irq", 8'h01, {7'h00, irq});
    host_model_inst.wr(8'h00, 8'h08);
    cyc(2);
    chk("irq", 8'h00, {7'h00, irq});
    comparator_trip = 1'b1;
    cyc(1);
    comparator_trip = 1'b0;
    cyc(2);
    chk("irq", 8'h01, {7'h00, irq});
    host_model_inst.wr(8'h00, 8'h08);
    cyc(2);
    chk("irq", 8'h00, {7'h00, irq});
    host_model_inst.start_light(8'h10, 8'h00);
    chk("enable", 8'h01, {7'h00, backlight_enable});
    chk("standby", 8'h01, {7'h00, standby_n});
    hold_time(1'b0);
    host_model_inst.start_light(8'h01, 8'h00);
    cyc(1);
    chk("dim set", 8'h01, {7'h00, dim_mode});
    hold_time(1'b1);
    chk("off timer idle", 8'h01, {7'h00, backlight_enable});
    host_model_inst.wr(8'h00, 8'h00);
    chk("disable", 8'h00, {7'h00, backlight_enable});
    complete_run();
  end
endmodule : testbench
